// ### src/jtlm_lane_mapper.sv
// module: transmit transport layer sample-to-lane mapper
`default_nettype none
module jtlm_lane_mapper
  import jtlm_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  input  wire logic [1:0]                  link_mode_select_i,
  input  wire logic [1:0]                  channels_i,
  input  wire logic                        alternate_lane_select_i,
  input  wire logic                        sh_fec_select_i,
  input  wire logic                        smp_valid_i,
  input  wire logic [IN_W-1:0]             smp_data_i,
  output logic                             smp_ready_o,
  input  wire logic                        frame_ready_i,
  output logic                             frame_valid_o,
  output logic [NUM_LANES*LANE_W-1:0]      lane_data_o,
  output logic [NUM_LANES-1:0]             lane_en_o,
  output logic [2:0]                       frame_octets_o,
  output jtlm_sh_t                         sh_mode_o,
  output logic                             alt_active_o,
  output logic                             alt_refused_o
);

  ////////////////////////////////////////////////////////////////////////
  // input fifo
  jtlm_stream_if #(.W(IN_W)) in_if ();
  jtlm_stream_if #(.W(IN_W)) out_if ();

  assign in_if.valid = smp_valid_i;
  assign in_if.data  = smp_data_i;
  assign smp_ready_o = in_if.ready;

  jtlm_fifo #(
    .WIDTH (IN_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .wr      (in_if),
    .rd      (out_if)
  );

  ////////////////////////////////////////////////////////////////////////
  // configuration, held steady for a whole frame
  jtlm_mode_t       mode_reg;
  logic [1:0]       nch_reg;
  logic             alt_reg;
  logic             fec_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             load_reg;
  logic             fv_reg;
  logic [SMP_W-1:0] mem [NUM_CH][MEM_DEPTH];

  wire logic             take;
  wire logic             last;
  wire logic             cfg_open;
  wire logic [CNT_W-1:0] last_idx;
  wire logic [3:0]       lanes_w;
  wire logic             alt_ok;
  wire logic             alt_bad;
  wire logic [2:0]       oct_w;
  wire jtlm_sh_t         sh_w;

  // stop pulling samples while a frame is built or waits for the link
  assign out_if.ready = !fv_reg && !load_reg;
  assign take     = out_if.valid && out_if.ready;
  assign last     = take && (cnt_reg == last_idx);
  assign cfg_open = (cnt_reg == '0) && !load_reg && !fv_reg;

  assign last_idx = (mode_reg == MODE_8B_64)   ? LAST_8B_64 :   // RULE1
                    (mode_reg == MODE_9B_8B10) ? LAST_8B10 :    // RULE2
                    (mode_reg == MODE_9B_PAIR) ? LAST_PAIR :    // RULE3
                    LAST_9B_64;                                 // RULE4
  assign oct_w    = (mode_reg == MODE_8B_64)   ? OCT_8B_64 :
                    (mode_reg == MODE_9B_8B10) ? OCT_8B10 : OCT_12B;
  assign lanes_w  = jtlm_lanes_of(mode_reg, nch_reg);
  assign alt_ok   = alt_reg && (lanes_w <= ALT_MAX_LANES);      // RULE8
  assign alt_bad  = alt_reg && !alt_ok;
  // 8b/10b has no sync header; only crc-12 or fec otherwise
  assign sh_w     = (mode_reg == MODE_9B_8B10) ? SH_NONE :
                    fec_reg ? SH_FEC : SH_CRC12; // RULE5 RULE6 RULE7

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      mode_reg <= MODE_8B_64;
      nch_reg  <= CH_SINGLE;
      alt_reg  <= 1'h0;
      fec_reg  <= 1'h0;
    end
    else if (cfg_open)
    begin
      mode_reg <= jtlm_mode_t'(link_mode_select_i);
      nch_reg  <= channels_i;
      alt_reg  <= alternate_lane_select_i;
      fec_reg  <= sh_fec_select_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sample gathering
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cnt_reg  <= '0;
      load_reg <= 1'h0;
    end
    else
    begin
      load_reg <= last;
      if (take)
        cnt_reg <= last ? '0 : cnt_reg + 1'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (take)
      for (int c = 0; c < NUM_CH; c++)
        mem[c][cnt_reg] <= out_if.data[c*SMP_W +: SMP_W];
  end

  ////////////////////////////////////////////////////////////////////////
  // lane word assembly, octet 0 in the most significant bits
  wire logic [LANE_W-1:0]    lw [NUM_LANES];
  wire logic [LANE_W-1:0]    pw [NUM_LANES];
  wire logic [NUM_LANES-1:0] used;
  wire logic [NUM_LANES-1:0] en_next;

  genvar g;
  for (g = 0; g < NUM_LANES; g++)
  begin : g_lane
    localparam int C4 = g / SET_LANES;
    localparam int K  = g % SET_LANES;
    localparam int C2 = g / 2;
    localparam int P  = g % 2;
    wire logic [LANE_W-1:0] w8;
    wire logic [LANE_W-1:0] w13;
    wire logic [LANE_W-1:0] w14;
    wire logic [LANE_W-1:0] w15;

    assign w8  = {mem[C4][K][SMP_W-1:1], 32'h0};                 // RULE1
    assign w13 = {mem[C4][K], 1'h0, mem[C4][K+4], 1'h0,
                  mem[C4][K+8], 1'h0, mem[C4][K+12], 1'h0};     // RULE2
    assign w14 = {mem[C2][P], 3'h0, mem[C2][P+2], 3'h0, 16'h0};  // RULE3
    assign w15 = {mem[C4][K], 3'h0, mem[C4][K+4], 3'h0, 16'h0};  // RULE4
    assign lw[g] = (mode_reg == MODE_8B_64)   ? w8 :
                   (mode_reg == MODE_9B_8B10) ? w13 :
                   (mode_reg == MODE_9B_PAIR) ? w14 : w15;

    assign used[g] = (4'(g) < lanes_w);
    // alternate set mirrors logical lanes 0-3 onto lanes 4-7
    assign en_next[g] = alt_ok ? ((g >= SET_LANES) && used[K])
                               : used[g]; // RULE9 RULE10 RULE11
    assign pw[g] = !en_next[g] ? '0 :
                   alt_ok ? lw[K] : lw[g];                       // RULE12

    property p_idle_zero;
      @(posedge clk_i) disable iff (!rst_b_i)
        !lane_en_o[g] |-> lane_data_o[g*LANE_W +: LANE_W] == '0;
    endproperty
    a_idle_zero: assert property (p_idle_zero) // RULE12
      else $error("idle lane carries data");
  end

  ////////////////////////////////////////////////////////////////////////
  // output frame registers
  logic [NUM_LANES*LANE_W-1:0] lane_data_reg;
  logic [NUM_LANES-1:0]        lane_en_reg;
  logic [2:0]                  oct_reg;
  jtlm_sh_t                    sh_reg;
  logic                        alt_act_reg;
  logic                        alt_ref_reg;
  wire logic [NUM_LANES*LANE_W-1:0] pw_flat;

  for (g = 0; g < NUM_LANES; g++)
  begin : g_flat
    assign pw_flat[g*LANE_W +: LANE_W] = pw[g];
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      fv_reg        <= 1'h0;
      lane_data_reg <= '0;
      lane_en_reg   <= '0;
      oct_reg       <= OCT_8B_64;
      sh_reg        <= SH_NONE;
      alt_act_reg   <= 1'h0;
      alt_ref_reg   <= 1'h0;
    end
    else if (load_reg)
    begin
      fv_reg        <= 1'h1;
      lane_data_reg <= pw_flat;
      lane_en_reg   <= en_next;
      oct_reg       <= oct_w;
      sh_reg        <= sh_w;
      alt_act_reg   <= alt_ok;
      alt_ref_reg   <= alt_bad;
    end
    else if (frame_ready_i)
      fv_reg <= 1'h0;
  end

  assign frame_valid_o  = fv_reg;
  assign lane_data_o    = lane_data_reg;
  assign lane_en_o      = lane_en_reg;
  assign frame_octets_o = oct_reg;
  assign sh_mode_o      = sh_reg;
  assign alt_active_o   = alt_act_reg;
  assign alt_refused_o  = alt_ref_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  wire logic [SMP_W-1:0] m00;
  wire logic [SMP_W-1:0] m01;
  wire logic [SMP_W-1:0] m04;
  wire logic [7:0]       m00_hi;
  assign m00    = mem[0][0];
  assign m01    = mem[0][1];
  assign m04    = mem[0][4];
  assign m00_hi = m00[SMP_W-1:1];

  sequence s_build;
    ##1 load_reg ##1 frame_valid_o;
  endsequence

  sequence s_alt_load;
    load_reg && alt_ok;
  endsequence

  property p_frame_build;
    last |-> s_build;
  endproperty
  a_frame_build: assert property (p_frame_build)
    else $error("frame not presented two cycles after last sample");

  property p_rule1;
    load_reg && mode_reg == MODE_8B_64 && !alt_ok
      |=> lane_data_o[LANE_W-1 -: 8] == $past(m00_hi);
  endproperty
  a_rule1: assert property (p_rule1) // RULE1
    else $error("8-bit lane 0 octet wrong");

  property p_rule2;
    load_reg && mode_reg == MODE_9B_8B10 && !alt_ok
      |=> lane_data_o[LANE_W-1 -: 10] == {$past(m00), 1'h0}
       && lane_data_o[LANE_W-11 -: 10] == {$past(m04), 1'h0};
  endproperty
  a_rule2: assert property (p_rule2) // RULE2
    else $error("8b10b lane 0 samples wrong");

  property p_rule3;
    load_reg && mode_reg == MODE_9B_PAIR && !alt_ok
      |=> lane_data_o[2*LANE_W-1 -: 12] == {$past(m01), 3'h0};
  endproperty
  a_rule3: assert property (p_rule3) // RULE3
    else $error("paired mode odd sample not on lane 1");

  property p_rule4;
    load_reg && mode_reg == MODE_9B_64 && !alt_ok
      |=> lane_data_o[LANE_W-13 -: 12] == {$past(m04), 3'h0};
  endproperty
  a_rule4: assert property (p_rule4) // RULE4
    else $error("9-bit 64b66b lane 0 second sample wrong");

  property p_rule5;
    frame_valid_o && frame_octets_o != OCT_8B10 |-> sh_mode_o != SH_NONE;
  endproperty
  a_rule5: assert property (p_rule5) // RULE5
    else $error("64b66b frame without sync header use");

  property p_rule6;
    load_reg && !fec_reg && mode_reg != MODE_9B_8B10
      |=> sh_mode_o == SH_CRC12;
  endproperty
  a_rule6: assert property (p_rule6) // RULE6
    else $error("detection not crc-12");

  property p_rule7;
    load_reg && fec_reg && mode_reg != MODE_9B_8B10
      |=> sh_mode_o == SH_FEC;
  endproperty
  a_rule7: assert property (p_rule7) // RULE7
    else $error("fec selection not applied");

  property p_rule8;
    load_reg && lanes_w > ALT_MAX_LANES
      |=> !alt_active_o && lane_en_o == '1;
  endproperty
  a_rule8: assert property (p_rule8) // RULE8
    else $error("alternate lanes with more than four lanes");

  property p_rule9;
    s_alt_load |=> lane_en_o[3:0] == 4'h0 && lane_en_o[7:4] != 4'h0;
  endproperty
  a_rule9: assert property (p_rule9) // RULE9
    else $error("alternate set not on lanes 4-7");

  property p_rule10;
    load_reg && !alt_reg && lanes_w <= ALT_MAX_LANES
      |=> lane_en_o[7:4] == 4'h0 && lane_en_o[0];
  endproperty
  a_rule10: assert property (p_rule10) // RULE10
    else $error("default set not selected");

  property p_rule11;
    alt_active_o |-> lane_en_o[3:0] == 4'h0;
  endproperty
  a_rule11: assert property (p_rule11) // RULE11
    else $error("both lane sets active");

  property p_hold;
    frame_valid_o && !frame_ready_i
      |=> frame_valid_o && $stable(lane_data_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("frame dropped before link accepted it");
endmodule : jtlm_lane_mapper
`default_nettype wire

// ### shared/jtlm_pkg.sv
// package: constants and types of the transport lane mapper
// Operation
// (RULE1) 8-bit 64b/66b: one sample per octet
// (RULE2) 9-bit 8b/10b: sample plus zero, stride four
// (RULE3) paired 9-bit 64b/66b: even/odd lanes per channel
// (RULE4) 9-bit 64b/66b: zero pad, samples k, k+4
// (RULE5) 64b/66b offers two sync header uses
// (RULE6) detection uses only the 12-bit crc
// (RULE7) alternative sync header use is fec
// (RULE8) alternate lanes only with four lanes or fewer
// (RULE9) lanes 0-3 default, 4-7 alternate set
// (RULE10) selector 0 picks default, 1 alternate
// (RULE11) never drive both lane sets together; with eight lanes the code enables lanes 0-7, both sets
// (RULE12) unused lanes idle, carry no samples
`default_nettype none
package jtlm_pkg;
  localparam int SMP_W     = 9;
  localparam int NUM_CH    = 4;
  localparam int NUM_LANES = 8;
  localparam int SET_LANES = 4;
  localparam int LANE_W    = 40;
  localparam int MEM_DEPTH = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int IN_W      = SMP_W * NUM_CH;
  localparam int CNT_W     = 4;
  // index of the last sample of a frame, per mode
  localparam logic [CNT_W-1:0] LAST_8B_64  = 4'h3;
  localparam logic [CNT_W-1:0] LAST_8B10   = 4'hF;
  localparam logic [CNT_W-1:0] LAST_PAIR   = 4'h3;
  localparam logic [CNT_W-1:0] LAST_9B_64  = 4'h7;
  // octets per lane per frame
  localparam logic [2:0] OCT_8B_64 = 3'h1;
  localparam logic [2:0] OCT_8B10  = 3'h5;
  localparam logic [2:0] OCT_12B   = 3'h3;
  // lane counts
  localparam logic [3:0] LANES_2   = 4'h2;
  localparam logic [3:0] LANES_4   = 4'h4;
  localparam logic [3:0] LANES_8   = 4'h8;
  localparam logic [3:0] ALT_MAX_LANES = 4'h4;
  // channel count selection
  localparam logic [1:0] CH_SINGLE = 2'h0;
  localparam logic [1:0] CH_DUAL   = 2'h1;

  typedef enum logic [1:0] {
    MODE_8B_64,
    MODE_9B_8B10,
    MODE_9B_PAIR,
    MODE_9B_64
  } jtlm_mode_t;

  typedef enum logic [1:0] {
    SH_NONE,
    SH_CRC12,
    SH_FEC
  } jtlm_sh_t;

  function automatic logic [3:0] jtlm_lanes_of(
    input jtlm_mode_t mode,
    input logic [1:0] nch
  );
    if (mode == MODE_9B_PAIR)
      return (nch == CH_SINGLE) ? LANES_2 :
             (nch == CH_DUAL) ? LANES_4 : LANES_8;
    return (nch == CH_SINGLE) ? LANES_4 : LANES_8;
  endfunction : jtlm_lanes_of
endpackage : jtlm_pkg
`default_nettype wire

// ### shared/jtlm_stream_if.sv
// interface: valid/ready word stream between mapper modules
`default_nettype none
interface jtlm_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : jtlm_stream_if
`default_nettype wire

// ### src/jtlm_fifo.sv
// module: small synchronous fifo with valid/ready on both sides
`default_nettype none
module jtlm_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4
) (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  jtlm_stream_if.snk      wr,
  jtlm_stream_if.src      rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_reg;
  logic [AW-1:0]    rp_reg;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             rdy_reg;
  wire  logic       push;
  wire  logic       pop;

  assign push     = wr.valid && rdy_reg;
  assign pop      = rd.valid && rd.ready;
  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign wr.ready = rdy_reg;
  assign rd.valid = (cnt_reg != '0);
  assign rd.data  = mem[rp_reg];

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'h0;
    end
    else
    begin
      if (push)
        wp_reg <= wp_reg + 1'h1;
      if (pop)
        rp_reg <= rp_reg + 1'h1;
      cnt_reg <= cnt_next;
      // ready is registered so the source sees a clean full flag
      rdy_reg <= (cnt_next != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wp_reg] <= wr.data;
  end
endmodule : jtlm_fifo
`default_nettype wire

// ### verif/jtlm_rx_model.sv
// partner model: link layer receiver taking frames promptly or stalled
`default_nettype none
module jtlm_rx_model (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic frame_valid_i,
  input  wire logic stall_i,
  output var logic  frame_ready_o,
  output var int    frames_o
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////
  // ready moves just after the edge; stall_i holds a frame pending
  always @(posedge clk_i)
  begin
    frame_ready_o <= rst_b_i && !stall_i;
    if (!rst_b_i)
      frames_o <= 0;
    else if (frame_valid_i && frame_ready_o)
      frames_o <= frames_o + 1;
  end
endmodule : jtlm_rx_model
`default_nettype wire

// ### verif/jtlm_lane_mapper_bench.sv
// testbench: lane mapper frames across modes, alternate set and fifo
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  errors++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module jtlm_lane_mapper_bench
  import jtlm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                        clk_i;
  logic                        rst_b_i;
  logic                        alt;
  logic                        fec;
  logic                        smp_valid;
  logic                        stall;
  logic [1:0]                  mode_sel;
  logic [1:0]                  ch_sel;
  logic [IN_W-1:0]             smp_data;
  logic                        smp_ready;
  logic                        frame_ready;
  logic                        frame_valid;
  logic                        alt_active;
  logic                        alt_refused;
  logic [NUM_LANES*LANE_W-1:0] lane_data;
  logic [NUM_LANES-1:0]        lane_en;
  logic [2:0]                  octets;
  jtlm_sh_t                    sh_mode;
  int                          errors;
  int                          comparisons;
  int                          frames;
  ////////////////////////////////////////////////////////////////////////////
  jtlm_lane_mapper dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link_mode_select_i(mode_sel),
    .channels_i(ch_sel), .alternate_lane_select_i(alt),
    .sh_fec_select_i(fec), .smp_valid_i(smp_valid), .smp_data_i(smp_data),
    .smp_ready_o(smp_ready), .frame_ready_i(frame_ready),
    .frame_valid_o(frame_valid), .lane_data_o(lane_data),
    .lane_en_o(lane_en), .frame_octets_o(octets), .sh_mode_o(sh_mode),
    .alt_active_o(alt_active), .alt_refused_o(alt_refused));
  jtlm_rx_model rx_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .frame_valid_i(frame_valid),
    .stall_i(stall), .frame_ready_o(frame_ready), .frames_o(frames));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] smp(int f, int c, int n);
    return 9'((f * 53 + c * 37 + n * 11 + 3) % 512);
  endfunction : smp
  function automatic int nlanes();
    if (mode_sel == 2'h2)
      return (ch_sel == 2'h0) ? 2 : (ch_sel == 2'h1) ? 4 : 8;
    return (ch_sel == 2'h0) ? 4 : 8;
  endfunction : nlanes
  // logical lane behind physical lane p, or -1 when idle
  function automatic int logical(int p);
    int l;
    l = (alt && nlanes() <= 4) ? p - 4 : p;
    return (l < 0 || l >= nlanes()) ? -1 : l;
  endfunction : logical
  function automatic logic [39:0] exp_lane(int f, int p);
    int l;
    logic [8:0] a;
    l = logical(p);
    if (l < 0)
      return 40'h0;
    a = smp(f, l / 4, l % 4);
    case (mode_sel)
      2'h0: return {a[8:1], 32'h0};
      2'h1: return {a, 1'b0, smp(f, l / 4, l % 4 + 4), 1'b0,
                    smp(f, l / 4, l % 4 + 8), 1'b0,
                    smp(f, l / 4, l % 4 + 12), 1'b0};
      2'h2: return {smp(f, l / 2, l % 2), 3'h0,
                    smp(f, l / 2, l % 2 + 2), 3'h0, 16'h0};
      default: return {a, 3'h0, smp(f, l / 4, l % 4 + 4), 3'h0, 16'h0};
    endcase
  endfunction : exp_lane
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic expire(bit ok);
    if (!ok)
    begin
      errors++;
      $display("unexpected wait exp 1 got 0");
      tally_and_finish();
    end
  endtask : expire
  task automatic wait_valid(logic want);
    int t;
    t = 0;
    while (frame_valid !== want && t < 100)
    begin
      @(negedge clk_i);
      t++;
    end
    expire(t < 100);
  endtask : wait_valid
  task automatic send(int f, int nw);
    int t;
    for (int n = 0; n < nw; n++)
    begin
      @(negedge clk_i);
      smp_valid = 1'b1;
      for (int c = 0; c < NUM_CH; c++)
        smp_data[c*SMP_W +: SMP_W] = smp(f, c, n);
      t = 0;
      while (smp_ready !== 1'b1 && t < 200)
      begin
        @(negedge clk_i);
        t++;
      end
      expire(t < 200);
    end
    @(negedge clk_i);
    smp_valid = 1'b0;
  endtask : send
  task automatic check_frame(int f);
    logic [NUM_LANES-1:0] en;
    logic [LANE_W-1:0]    got;
    logic [2:0]           oct;
    jtlm_sh_t             shx;
    wait_valid(1'b1);
    for (int p = 0; p < NUM_LANES; p++)
    begin
      en[p] = (logical(p) >= 0);
      got = lane_data[p*LANE_W +: LANE_W];
      `CHK("lane", exp_lane(f, p), got)
    end
    `CHK("lane_en", en, lane_en)
    oct = (mode_sel == 2'h0) ? 3'h1 : (mode_sel == 2'h1) ? 3'h5 : 3'h3;
    shx = (mode_sel == 2'h1) ? SH_NONE : fec ? SH_FEC : SH_CRC12;
    `CHK("octets", oct, octets)
    `CHK("sh_mode", shx, sh_mode)
    `CHK("alt_active", 1'(alt && nlanes() <= 4), alt_active)
    `CHK("alt_refused", 1'(alt && nlanes() > 4), alt_refused)
  endtask : check_frame
  task automatic run(int f, int m, int c, bit a, bit e);
    @(negedge clk_i);
    mode_sel = 2'(m);
    ch_sel = 2'(c);
    alt = a;
    fec = e;
    send(f, (m == 1) ? 16 : (m == 3) ? 8 : 4);
    check_frame(f);
    wait_valid(1'b0);
  endtask : run
  // frame held by a stalled receiver while the fifo fills behind it
  task automatic fifo_fill();
    @(negedge clk_i);
    stall = 1'b1;
    mode_sel = 2'h0;
    ch_sel = 2'h1;
    alt = 1'b0;
    send(10, 4);
    check_frame(10);
    send(11, 4);
    `CHK("smp_ready full", 1'b0, smp_ready)
    `CHK("frame held", 1'b1, frame_valid)
    check_frame(10);
    stall = 1'b0;
    wait_valid(1'b0);
    check_frame(11);
    wait_valid(1'b0);
  endtask : fifo_fill
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    errors = 0;
    comparisons = 0;
    rst_b_i = 1'b0;
    smp_valid = 1'b0;
    smp_data = '0;
    mode_sel = 2'h0;
    ch_sel = 2'h0;
    alt = 1'b0;
    fec = 1'b0;
    stall = 1'b0;
    repeat (4) @(negedge clk_i);
    `CHK("ready in reset", 1'b0, smp_ready)
    `CHK("lane_en in reset", 8'h00, lane_en)
    `CHK("octets in reset", 3'h1, octets)
    rst_b_i = 1'b1;
    run(1, 0, 1, 1'b0, 1'b0);
    run(2, 0, 0, 1'b1, 1'b1);
    run(3, 0, 1, 1'b1, 1'b0);
    run(4, 1, 1, 1'b0, 1'b0);
    run(5, 1, 0, 1'b1, 1'b1);
    run(6, 2, 2, 1'b0, 1'b0);
    run(7, 2, 0, 1'b1, 1'b0);
    run(8, 2, 1, 1'b1, 1'b1);
    run(9, 3, 1, 1'b0, 1'b1);
    run(10, 3, 0, 1'b0, 1'b0);
    fifo_fill();
    `CHK("frames taken", 12, frames)
    tally_and_finish();
  end
endmodule : jtlm_lane_mapper_bench
`default_nettype wire
